// File: include/srwin_consts.svh
`ifndef SRWIN_CONSTS_SVH
`define SRWIN_CONSTS_SVH

// register offsets
`define SRWIN_OFS_MAP_LOW    8'h2c
`define SRWIN_OFS_MAP_MID    8'h2d
`define SRWIN_OFS_MAP_HIGH   8'h2e
`define SRWIN_OFS_TAP_SEL    8'h2f
`define SRWIN_OFS_FINE_STEP  8'h30

// field layout
`define SRWIN_MAP_BITS       24
`define SRWIN_MAP_LAST       23
`define SRWIN_SEL_BITS       4
`define SRWIN_FINE_BIT       0

// reset values
`define SRWIN_RST_MAP        24'hff_ffff
`define SRWIN_RST_TAP_SEL    4'h0
`define SRWIN_RST_FINE_STEP  1'b1

// synchroniser depth
`define SRWIN_SYNC_STAGES    2

`endif

// File: include/srwin_pkg.sv
package srwin_pkg;
  typedef logic [23:0] srwin_map_t;
  typedef logic [3:0]  srwin_sel_t;
  typedef logic [7:0]  srwin_byte_t;
endpackage

// File: sim/srwin_ref_src.sv
`timescale 1ns/1ps
module srwin_ref_src (
  input  wire logic        ref_clk_i,
  input  wire logic        fire_i,
  input  wire logic [23:0] window_i,
  output logic      [23:0] tap_samples_o
);
  // taps copy window_i while fire_i is high, idle low otherwise
  initial tap_samples_o = 24'h00_0000;
  always @(posedge ref_clk_i) tap_samples_o <= #1 fire_i ? window_i : 24'h00_0000;
endmodule

// File: sim/srwin_top_chk.sv
`timescale 1ns/1ps
module srwin_top_chk (
  input wire logic       ref_clk_i,
  input wire logic       rst_b_i,
  input wire logic       fine_step_enable_o,
  input wire logic       sysref_captured_o,
  input wire logic       frame_counter_reset_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence rd_s(logic [7:0] a); reg_rd_i && reg_addr_i == a; endsequence
  sequence wr_s(logic [7:0] a); reg_wr_i && reg_addr_i == a; endsequence
  pulse_one_a: assert property (frame_counter_reset_o |=> !frame_counter_reset_o) else $error("pulse long");
  pulse_cause_a: assert property (frame_counter_reset_o |-> $rose(sysref_captured_o)) else $error("bad pulse");
  fine_set_a: assert property (wr_s(8'h30) ##0 reg_wdata_i[0] |=> fine_step_enable_o) else $error("fine");
  coarse_set_a: assert property (wr_s(8'h30) ##0 !reg_wdata_i[0] |=> !fine_step_enable_o) else $error("coarse");
  fine_hold_a: assert property (!(reg_wr_i && reg_addr_i == 8'h30) |=> $stable(fine_step_enable_o))
    else $error("step moved");
  map_low_a: assert property (rd_s(8'h2c) |=> reg_rdata_o[0]) else $error("bit 0 clear");
  map_top_a: assert property (rd_s(8'h2e) |=> reg_rdata_o[7]) else $error("bit 23 clear");
  sel_width_a: assert property (rd_s(8'h2f) |=> reg_rdata_o[7:4] == 4'h0) else $error("select wide");
  unmapped_rd_a: assert property (reg_rd_i && (reg_addr_i < 8'h2c || reg_addr_i > 8'h30) |=> reg_rdata_o == 8'h00)
    else $error("unmapped data");
endmodule

// File: sim/tb_srwin_top.sv
`timescale 1ns/1ps
module tb_srwin_top;
  logic        ref_clk_i = 1'h0, rst_b_i = 1'h0, fire = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic        fine_step_enable_o, sysref_captured_o, frame_counter_reset_o;
  logic [23:0] tap_samples_i, window = 24'h00_0000;
  logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  int          failures = 0, tests_run = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  srwin_ref_src srwin_ref_src_i (.ref_clk_i, .fire_i(fire), .window_i(window), .tap_samples_o(tap_samples_i));
  srwin_top srwin_top_i (.ref_clk_i, .rst_b_i, .tap_samples_i, .fine_step_enable_o, .sysref_captured_o,
    .frame_counter_reset_o, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o);
  task automatic chk(input logic [23:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr_i = a; reg_wdata_i = d; reg_wr_i = 1'h1;
    @(posedge ref_clk_i) #1 reg_wr_i = 1'h0;
    @(posedge ref_clk_i) #1;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    reg_addr_i = a; reg_rd_i = 1'h1;
    @(posedge ref_clk_i) #1 reg_rd_i = 1'h0;
    chk(reg_rdata_o, exp);
    @(posedge ref_clk_i) #1;
  endtask
  task automatic t_reset;
    logic [7:0] e [7] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h01, 8'h00};
    for (int i = 0; i < 7; i++) rd(8'h2b + i[7:0], e[i]);
    chk(fine_step_enable_o, 1'h1);
  endtask
  task automatic t_regs;
    wr(8'h2f, 8'hf7);
    rd(8'h2f, 8'h07);
    wr(8'h30, 8'h00);
    chk(fine_step_enable_o, 1'h0);
    wr(8'h2c, 8'h00);
    rd(8'h2c, 8'hff);
    wr(8'h30, 8'h01);
    chk(fine_step_enable_o, 1'h1);
  endtask
  task automatic t_pulse;
    wr(8'h2f, 8'h09);
    window = 24'h00_fff0; fire = 1'h1;
    for (int i = 0; i < 8 && frame_counter_reset_o !== 1'h1; i++) @(posedge ref_clk_i) #1;
    chk(frame_counter_reset_o, 1'h1);
    chk(sysref_captured_o, 1'h1);
    @(posedge ref_clk_i) #1 fire = 1'h0;
    chk(frame_counter_reset_o, 1'h0);
    rd(8'h2c, 8'h19);
    rd(8'h2d, 8'h80);
    rd(8'h2e, 8'h81);
  endtask
  task automatic t_status;
    window = 24'h1f_0000; fire = 1'h1;
    repeat (5) @(posedge ref_clk_i) #1;
    chk(sysref_captured_o, 1'h0);
    fire = 1'h0;
    rd(8'h2e, 8'hb1);
    rd(8'h2c, 8'h01);
  endtask
  task automatic t_rerun;
    rst_b_i = 1'h0;
    repeat (4) @(posedge ref_clk_i) #1;
    rst_b_i = 1'h1;
    rd(8'h2e, 8'hff);
    chk(fine_step_enable_o, 1'h1);
    rd(8'h2f, 8'h00);
    wr(8'h2f, 8'h09);
    rd(8'h2f, 8'h09);
  endtask
  task automatic report_and_stop;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    #1 rst_b_i = 1'h1;
    t_reset; t_regs; t_pulse; t_status; t_rerun;
    report_and_stop;
  end
  initial begin
    #100000 failures++;
    report_and_stop;
  end
endmodule
bind srwin_top srwin_top_chk srwin_top_chk_i (.ref_clk_i, .rst_b_i, .fine_step_enable_o, .sysref_captured_o,
  .frame_counter_reset_o, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o);

// File: src/srwin_sync.sv
`timescale 1ns/1ps
module srwin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  // data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// File: src/srwin_top.sv
`timescale 1ns/1ps
`include "srwin_consts.svh"

// Behaviour
// - timing reference is latched on a fixed clock edge, repeatable at every power-on.
// - reference sampled by a selectable delayed copy of the input clock.
// - position of reference in clock cycle stored as 24-bit phase map.
// - map bit 1 marks possible setup/hold violation, 0 marks valid position.
// - fine step bit sets delay increment; 0 coarse, 1 fine.
// - map bits 0 and 23 always read 1.
// - tap select reaches only positions 0 through 15.
// - map bits 16 to 23 are status only, no effect on capture.
// - captured reference resets the local multiframe or multiblock counter.
module srwin_top (
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_b_i,
  // reference samples from the delay line taps, one per candidate position
  input  wire logic [23:0]          tap_samples_i,
  // delay line step control
  output logic                      fine_step_enable_o,
  // capture path
  output logic                      sysref_captured_o,
  output logic                      frame_counter_reset_o,
  // register port
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic                 reg_wr_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic                 reg_rd_i,
  output logic [7:0]                reg_rdata_o
);
  srwin_pkg::srwin_map_t samp;
  srwin_pkg::srwin_map_t samp_q;
  srwin_pkg::srwin_map_t ref_phase_map;
  srwin_pkg::srwin_sel_t capture_tap_select;
  logic                  cap_q;

  // tap sample inputs pass two flops before any logic
  srwin_sync #(
    .WIDTH (`SRWIN_MAP_BITS)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   (tap_samples_i),
    .sync_o    (samp)
  );

  // a tap disagreeing with a neighbour sits in the transition region
  wire srwin_pkg::srwin_map_t transition;
  srwin_pkg::srwin_map_t next_map;
  wire logic             edge_seen;
  wire logic             cap_now;
  wire logic             cap_rise;

  genvar g;
  generate
    for (g = 1; g < `SRWIN_MAP_LAST; g++) begin : g_trans
      assign transition[g] = (samp[g] ^ samp[g-1]) | (samp[g] ^ samp[g+1]);
    end
  endgenerate
  assign transition[0]               = 1'b1;
  assign transition[`SRWIN_MAP_LAST] = 1'b1;

  assign next_map  = transition;
  assign edge_seen = |(samp & ~samp_q);
  // only the low 16 taps reach the capture path
  assign cap_now   = samp[{1'b0, capture_tap_select}];
  assign cap_rise  = cap_now & ~cap_q;

  wire logic sel_map_low  = (reg_addr_i == `SRWIN_OFS_MAP_LOW);
  wire logic sel_map_mid  = (reg_addr_i == `SRWIN_OFS_MAP_MID);
  wire logic sel_map_high = (reg_addr_i == `SRWIN_OFS_MAP_HIGH);
  wire logic sel_tap      = (reg_addr_i == `SRWIN_OFS_TAP_SEL);
  wire logic sel_fine     = (reg_addr_i == `SRWIN_OFS_FINE_STEP);

  srwin_pkg::srwin_byte_t next_rdata;
  assign next_rdata = sel_map_low  ? ref_phase_map[7:0]   :
                      sel_map_mid  ? ref_phase_map[15:8]  :
                      sel_map_high ? ref_phase_map[23:16] :
                      sel_tap      ? {4'h0, capture_tap_select} :
                      sel_fine     ? {7'h00, fine_step_enable_o} :
                                     8'h00;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      samp_q        <= '0;
      ref_phase_map <= `SRWIN_RST_MAP;
    end else begin
      samp_q <= samp;
      if (edge_seen) begin
        ref_phase_map <= next_map;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      capture_tap_select <= `SRWIN_RST_TAP_SEL;
      fine_step_enable_o <= `SRWIN_RST_FINE_STEP;
    end else if (reg_wr_i) begin
      if (sel_tap) begin
        capture_tap_select <= reg_wdata_i[3:0];
      end
      if (sel_fine) begin
        fine_step_enable_o <= reg_wdata_i[`SRWIN_FINE_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cap_q                 <= 1'b0;
      sysref_captured_o     <= 1'b0;
      frame_counter_reset_o <= 1'b0;
    end else begin
      cap_q                 <= cap_now;
      sysref_captured_o     <= cap_now;
      frame_counter_reset_o <= cap_rise;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end
endmodule
